// file: design/priority_arbiter.v
// Rotating two-class arbiter for the secondary-bus requesters.
// Assumes requests are synchronous levels on pclk; grant is registered, one-hot, or all zero when nothing is requested.
`timescale 1ns/1ns
`default_nettype none
`include "secondary_config_defs.vh"
module priority_arbiter (
  input wire pclk,
  input wire presetn,
  input wire [`NUM_REQ-1:0] req,
  input wire [`NUM_REQ-1:0] high_prio,
  output reg [`NUM_REQ-1:0] grant
);
  reg [3:0] last;
  reg [`NUM_REQ-1:0] next_grant;
  reg [`NUM_REQ-1:0] hi_req;
  reg [`NUM_REQ-1:0] pool;
  reg [3:0] idx;
  reg [4:0] sum;
  reg [4:0] wrapped;
  integer k;
  integer j;

  // High class wins if any of it is pending; rotation starts after the last winner.
  always @* begin
    next_grant = {`NUM_REQ{1'b0}};
    hi_req = req & high_prio;
    pool = (|hi_req) ? hi_req : req;
    idx = 4'h0;
    sum = 5'h00;
    wrapped = 5'h00;
    // Five-bit sum: pointer plus step reaches 17, which four bits would fold silently.
    for (k = `NUM_REQ; k >= 1; k = k - 1) begin
      sum = {1'b0, last} + {1'b0, k[3:0]};
      wrapped = sum - 5'd9;
      idx = (sum >= 5'd9) ? wrapped[3:0] : sum[3:0];
      if (pool[idx]) begin
        next_grant = {`NUM_REQ{1'b0}};
        next_grant[idx] = 1'b1;
      end
    end
  end

  // Grant and rotation pointer; the pointer only moves when someone is served.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grant <= {`NUM_REQ{1'b0}};
      last <= 4'h0;
    end else begin
      grant <= next_grant;
      for (j = 0; j < `NUM_REQ; j = j + 1) begin
        if (next_grant[j]) begin
          last <= j[3:0];
        end
      end
    end
  end
endmodule // priority_arbiter
`default_nettype wire

// file: design/secondary_config_defs.vh
// Offsets, field positions and reset values of the secondary configuration registers.
// Assumes inclusion by bare name from the design files; holds definitions only.
`ifndef SECONDARY_CONFIG_DEFS_VH
`define SECONDARY_CONFIG_DEFS_VH

`define OFF_PRIORITY 12'h048
`define OFF_LINE_TIMER_HDR 12'h04c
`define OFF_MEM0_BASE 12'h050
`define OFF_MEM0_SETUP 12'h0e4
`define OFF_MEM0_XLAT 12'h0e0
`define OFF_ARB_REQ 12'h100
`define OFF_ARB_GRANT 12'h104

`define PRIO_LSB 22
`define PRIO_MSB 30
`define PRIO_RESET 9'h001
`define LINE_LSB 2
`define LINE_MSB 5
`define LINE_RESET 4'h0
`define TIMER_LSB 8
`define TIMER_MSB 15
`define TIMER_RESET_PCI 8'h00
`define TIMER_RESET_PCIX 8'h40
`define HDR_KIND_RESET 16'h0000
`define BASE_LSB 12
`define BASE_MSB 31
`define BASE_RESET 20'h00000
`define BASE_ADDR_TYPE_RESET 2'h0
`define CSR_WINDOW_BITS 12
`define SETUP_RESET 32'h00000000
`define XLAT_RESET 32'h00000000
`define NUM_REQ 9

`endif

// file: design/secondary_config_regs.v
// Secondary-side configuration registers at 48h to 50h, E0h, E4h, 100h and 104h behind an APB slave, with the base
// address write mask and a small arbiter that uses the priority bits.
// Assumes a single pclk domain; mode straps are steady levels sampled after reset release.
//
// Functional notes
// - Internal requester priority bit 22, resets high.
// - Bits 23..30 priority of masters 1..8.
// - Line size bits 1:0 read zero.
// - Line size bits 2..5 select 4..32 DW.
// - Line size bits 7:6 read zero.
// - Reverse bridge: latency timer read-only 00h.
// - Forward: timer writable, reset 00h/40h by mode.
// - Header type bits 22:16 read zero.
// - Bit 23 zero, bits 31:24 read 00h.
// - Base bit 0 memory, bits 2:1 type.
// - Bit 3 prefetchable flag, bits 11:4 zero.
// - Base bits writable where setup bit set.
// - Lowest 4KB of window hits own CSRs.
// - Above 4KB claims upstream, translated via E0h.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "secondary_config_defs.vh"
module secondary_config_regs (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire reverse_mode,
  input wire pcix_mode,
  input wire prefetchable,
  input wire wide_decode,
  input wire [31:0] up_addr,
  input wire up_valid,
  input wire [`NUM_REQ-1:0] arb_req,
  output reg csr_hit,
  output reg fwd_hit,
  output reg [31:0] fwd_addr,
  output reg [3:0] line_size,
  output reg [7:0] latency_timer,
  output reg [`NUM_REQ-1:0] arb_grant
);
  reg [8:0] prio;
  reg [3:0] line_bits;
  reg [7:0] timer;
  reg [19:0] base;
  reg [31:0] setup;
  reg [31:0] xlat;
  reg strap_done;
  reg [31:0] next_prdata;
  reg mapped;
  wire [`NUM_REQ-1:0] grant_w;
  wire wr_take;
  wire rd_take;
  wire [31:0] base_word;
  wire [31:0] win_mask;
  wire in_window;

  // Access phase completes in the cycle penable first rises; pready is asserted for it.
  assign wr_take = psel & penable & pready & pwrite;
  assign rd_take = psel & penable & pready & ~pwrite;

  // Read-only low bits of the base register are fixed; the top field comes from storage.
  assign base_word = {base, 8'h00, prefetchable, 1'b0, wide_decode, 1'b0};

  // Window mask: setup bits mark the decoded address bits; clear bits give the window size.
  assign win_mask = {setup[31:12], 12'h000};
  assign in_window = ((up_addr & win_mask) == ({base, 12'h000} & win_mask)) & setup[31];

  // Register storage and APB write side.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio <= `PRIO_RESET;
      line_bits <= `LINE_RESET;
      timer <= `TIMER_RESET_PCI;
      base <= `BASE_RESET;
      setup <= `SETUP_RESET;
      xlat <= `XLAT_RESET;
      strap_done <= 1'b0;
    end else begin
      // Timer reset value depends on the bus mode strap, caught once after release.
      if (!strap_done) begin
        strap_done <= 1'b1;
        timer <= (reverse_mode || !pcix_mode) ? `TIMER_RESET_PCI : `TIMER_RESET_PCIX;
      end else if (reverse_mode) begin
        timer <= `TIMER_RESET_PCI;
      end
      if (wr_take) begin
        case (paddr)
          `OFF_PRIORITY: begin
            prio <= pwdata[`PRIO_MSB:`PRIO_LSB];
          end
          `OFF_LINE_TIMER_HDR: begin
            line_bits <= pwdata[`LINE_MSB:`LINE_LSB];
            if (!reverse_mode && strap_done) begin
              timer <= pwdata[`TIMER_MSB:`TIMER_LSB];
            end
          end
          `OFF_MEM0_BASE: begin
            // Only bits enabled by setup take the write; the rest keep their value.
            base <= (pwdata[`BASE_MSB:`BASE_LSB] & setup[31:12]) | (base & ~setup[31:12]);
          end
          `OFF_MEM0_SETUP: begin
            setup <= pwdata;
          end
          `OFF_MEM0_XLAT: begin
            xlat <= pwdata;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Read multiplexer; reserved and read-only-zero fields come back as zero.
  always @* begin
    next_prdata = 32'h00000000;
    mapped = 1'b1;
    case (paddr)
      `OFF_PRIORITY: next_prdata = {1'b0, prio, 22'h000000};
      `OFF_LINE_TIMER_HDR: next_prdata = {`HDR_KIND_RESET, timer, 2'b00, line_bits, 2'b00};
      `OFF_MEM0_BASE: next_prdata = base_word;
      `OFF_MEM0_SETUP: next_prdata = setup;
      `OFF_MEM0_XLAT: next_prdata = xlat;
      `OFF_ARB_REQ: next_prdata = {23'h000000, arb_req};
      `OFF_ARB_GRANT: next_prdata = {23'h000000, arb_grant};
      default: mapped = 1'b0;
    endcase
  end

  // APB answer: one wait-free access phase; unmapped addresses raise pslverr.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable & ~pwrite) begin
        prdata <= next_prdata;
      end
      if (rd_take) begin
        prdata <= prdata;
      end
    end
  end

  // Upstream decode: low 4KB of the window is our CSR space, the rest is forwarded.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csr_hit <= 1'b0;
      fwd_hit <= 1'b0;
      fwd_addr <= 32'h00000000;
      line_size <= 4'h0;
      latency_timer <= 8'h00;
      arb_grant <= {`NUM_REQ{1'b0}};
    end else begin
      csr_hit <= up_valid & in_window & (up_addr[31:12] == base);
      fwd_hit <= up_valid & in_window & (up_addr[31:12] != base);
      fwd_addr <= (xlat & win_mask) | (up_addr & ~win_mask);
      line_size <= line_bits;
      latency_timer <= timer;
      arb_grant <= grant_w;
    end
  end

  priority_arbiter arb (
    .pclk(pclk),
    .presetn(presetn),
    .req(arb_req),
    .high_prio(prio),
    .grant(grant_w)
  );
endmodule // secondary_config_regs
`default_nettype wire

// file: verification/cfg_regs_sva.sv
// Concurrent checks on the ports of the secondary configuration register block.
// Assumes a single pclk domain and an APB master that keeps the setup/access order.
`timescale 1ns/1ns
`default_nettype none
module cfg_regs_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic reverse_mode,
  input wire logic prefetchable,
  input wire logic wide_decode,
  input wire logic up_valid,
  input wire logic csr_hit,
  input wire logic fwd_hit,
  input wire logic [3:0] line_size,
  input wire logic [7:0] latency_timer,
  input wire logic [8:0] arb_grant
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A transfer is a setup step followed by one answered access step.
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_rd(a);
    pready && !pwrite && paddr == a;
  endsequence
  sequence s_wr(a);
    pready && pwrite && paddr == a;
  endsequence
  a_ready_first: assert property (s_setup |=> pready) else $error("no ready in access");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
  a_bad_addr: assert property (s_setup ##0 (!pwrite && paddr == 12'h0f0) |=> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  a_prio_top: assert property (s_rd(12'h048) |-> !prdata[31]) else $error("bit 31 set");
  a_line_rsvd: assert property (s_rd(12'h04c) |-> (prdata & 32'hffff00c3) == 32'h0)
    else $error("reserved bits set");
  a_base_low: assert property (s_rd(12'h050) |-> prdata[11:0] == {8'h00, prefetchable, 1'b0, wide_decode, 1'b0})
    else $error("base low bits wrong");
  a_line_copy: assert property (s_wr(12'h04c) |-> ##2 line_size == $past(pwdata[5:2], 2)) else $error("line size");
  a_timer_rev: assert property (reverse_mode |=> latency_timer == 8'h00) else $error("timer not zero");
  a_timer_fwd: assert property (s_wr(12'h04c) ##0 !reverse_mode |-> ##2 latency_timer == $past(pwdata[15:8], 2))
    else $error("timer not written");
  a_hit_cause: assert property (csr_hit || fwd_hit |-> $past(up_valid) && !(csr_hit && fwd_hit))
    else $error("bad hit");
  a_grant_one: assert property ($onehot0(arb_grant)) else $error("grant not one-hot");
endmodule // cfg_regs_sva
bind secondary_config_regs cfg_regs_sva cfg_regs_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .reverse_mode(reverse_mode), .prefetchable(prefetchable), .wide_decode(wide_decode),
  .up_valid(up_valid), .csr_hit(csr_hit), .fwd_hit(fwd_hit), .line_size(line_size),
  .latency_timer(latency_timer), .arb_grant(arb_grant));
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the secondary configuration register block.
// Assumes zero-wait APB answers and decode outputs one cycle after the address.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic pclk, presetn, psel, penable, pwrite, reverse_mode, pcix_mode, up_valid, pready, pslverr, csr_hit, fwd_hit;
  logic err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, up_addr, fwd_addr, rd;
  logic [3:0] line_size;
  logic [7:0] latency_timer;
  logic [8:0] arb_req, arb_grant;
  int bad_count, checks, i;
  secondary_config_regs secondary_config_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reverse_mode(reverse_mode), .pcix_mode(pcix_mode), .prefetchable(1'b1),
    .wide_decode(1'b1), .up_addr(up_addr), .up_valid(up_valid), .arb_req(arb_req), .csr_hit(csr_hit),
    .fwd_hit(fwd_hit), .fwd_addr(fwd_addr), .line_size(line_size), .latency_timer(latency_timer),
    .arb_grant(arb_grant));
  // Free-running bus clock.
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task chk(input [35:0] got, input [35:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request is held until pready is seen at an edge.
  task apb(input w, input [11:0] a, input [31:0] d);
    int n;
    n = 0;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) bad_count++;
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  task rchk(input [11:0] a, input [31:0] m, input [31:0] e);
    apb(1'b0, a, 32'h0);
    chk({4'h0, rd & m}, {4'h0, e});
  endtask
  // Straps only change while reset is held, so the timer reset value is always taken cleanly.
  task rst(input r, input x);
    {presetn, reverse_mode, pcix_mode} <= {1'b0, r, x};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask
  task final_report;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog far beyond the roughly 135 cycles the sequence needs.
  initial begin
    #200000;
    bad_count++;
    final_report;
  end
  // Main sequence: modes, priority, base mask and decode.
  initial begin
    {psel, penable, pwrite, up_valid, presetn, reverse_mode, pcix_mode} = 7'h00;
    {paddr, pwdata, up_addr, arb_req} = '0;
    for (i = 0; i < 3; i++) begin
      rst(i == 2, i != 1);
      rchk(12'h04c, 32'hffffffff, (i == 0) ? 32'h00004000 : 32'h0);
      apb(1'b1, 12'h04c, 32'hffffffff);
      rchk(12'h04c, 32'hffffffff, (i == 2) ? 32'h0000003c : 32'h0000ff3c);
      chk({24'h0, latency_timer, line_size}, (i == 2) ? 36'h00f : 36'hfff);
    end
    rchk(12'h048, 32'hffc00000, 32'h00400000);
    apb(1'b1, 12'h048, 32'hffffffff);
    rchk(12'h048, 32'hffc00000, 32'h7fc00000);
    apb(1'b1, 12'h048, 32'h010001ff);
    arb_req <= 9'h007;
    repeat (3) @(posedge pclk);
    chk({27'h0, arb_grant}, 36'h004);
    apb(1'b1, 12'h050, 32'hffffffff);
    rchk(12'h050, 32'hffffffff, 32'h0000000a);
    apb(1'b1, 12'h0e4, 32'hfff00000);
    apb(1'b1, 12'h0e0, 32'h40000000);
    apb(1'b1, 12'h050, 32'h123fffff);
    rchk(12'h050, 32'hffffffff, 32'h1230000a);
    {up_valid, up_addr} <= {1'b1, 32'h12300010};
    repeat (2) @(posedge pclk);
    chk({34'h0, csr_hit, fwd_hit}, 36'h2);
    up_addr <= 32'h12301020;
    repeat (2) @(posedge pclk);
    chk({2'h0, csr_hit, fwd_hit, fwd_addr}, {4'h1, 32'h40001020});
    up_addr <= 32'h50000000;
    repeat (2) @(posedge pclk);
    chk({34'h0, csr_hit, fwd_hit}, 36'h0);
    up_valid <= 1'b0;
    apb(1'b0, 12'h0f0, 32'h0);
    chk({3'h0, err, rd}, {4'h1, 32'h0});
    final_report;
  end
endmodule // testbench
`default_nettype wire
